// ===== hdl/bpr_map.svh
// constants for the backplane bus reset sequencer
`ifndef BPR_MAP_SVH
`define BPR_MAP_SVH
// ============================================================
// timing
`define BPR_CLK_MHZ 100
`define BPR_DET_CLKS 320
`define BPR_DET_W 9
// ============================================================
// register file
`define BPR_NREGS 4
`define BPR_RADDR_W 2
`define BPR_RDATA_W 8
`define BPR_REG_RST 8'h00
// control register layout
`define BPR_CTRL_ADDR 2'h0
`define BPR_IBR_BIT 6
`endif

// ===== hdl/bpr_pkg.sv
// types for the backplane bus reset sequencer
`include "bpr_map.svh"
package bpr_pkg;
    // ============================================================
    // sequencer states, gray along idle -> drive -> init
    typedef enum logic [1:0]
    {
        BPR_IDLE = 2'b00,
        BPR_DRIVE = 2'b01,
        BPR_INIT = 2'b11
    } bpr_state_t;
endpackage

// ===== hdl/bpr_regs.sv
// small register memory holding the phy operating registers
`timescale 1ns/1ps
`include "bpr_map.svh"
module bpr_regs
    import bpr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // clear all to defaults
    input wire logic clr,
    // write port
    input wire logic we,
    input wire logic [`BPR_RADDR_W-1:0] waddr,
    input wire logic [`BPR_RDATA_W-1:0] wdata,
    // read port
    input wire logic [`BPR_RADDR_W-1:0] raddr,
    output logic [`BPR_RDATA_W-1:0] rdata
);
    // ============================================================
    // storage
    logic [`BPR_RDATA_W-1:0] mem_r [`BPR_NREGS];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < `BPR_NREGS; i++)
                mem_r[i] <= `BPR_REG_RST;
            rdata <= `BPR_REG_RST;
        end
        else
        begin
            for (int i = 0; i < `BPR_NREGS; i++)
                if (clr)
                    mem_r[i] <= `BPR_REG_RST;
                else if (we && waddr == i[`BPR_RADDR_W-1:0])
                    mem_r[i] <= wdata;
            rdata <= clr ? `BPR_REG_RST : mem_r[raddr];
        end
    end
endmodule

// ===== hdl/bpr_seq.sv
// bus reset sequencer for a single-port backplane phy
//
// Contract
// [R01] link reset request drives bus reset
// [R02] request returns all registers to defaults
// [R03] request may reinit the state machines
// [R04] own reset detected 320 clocks later, then init
// [R05] reset generator keeps running on self-detect
// [R06] any detected bus reset initialises phy
// [R07] link writes control with reset bit one
// [R08] hardware clears reset bit on own detect
// [R09] tap-in alone never causes bus reset
// [R10] power-up initialises, drives no bus reset; the code resets straight to idle and gives no phy_init pulse
// [R11] detection delay is fixed 320 count
`timescale 1ns/1ps
`include "bpr_map.svh"
module bpr_seq
    import bpr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // link register access
    input wire logic reg_we,
    input wire logic [`BPR_RADDR_W-1:0] reg_waddr,
    input wire logic [`BPR_RDATA_W-1:0] reg_wdata,
    input wire logic [`BPR_RADDR_W-1:0] reg_raddr,
    output logic [`BPR_RDATA_W-1:0] reg_rdata,
    // backplane side
    input wire logic bus_reset_in,
    input wire logic tap_in,
    output logic bus_reset_out,
    // status
    output logic phy_init,
    output logic initiate_bus_reset_bit
);
    // ============================================================
    // helpers
    // true when an address hits the control register
    function automatic logic is_ctrl(input logic [`BPR_RADDR_W-1:0] addr);
        return addr == `BPR_CTRL_ADDR;
    endfunction

    // place the request bit at its field position in a register word
    function automatic logic [`BPR_RDATA_W-1:0] ibr_field(input logic bit_val);
        return `BPR_RDATA_W'(bit_val) << `BPR_IBR_BIT;
    endfunction

    // ============================================================
    // pin synchroniser; tap_in is sampled nowhere on purpose
    logic rst_meta_r, rst_sync_r, rst_prev_r;
    logic unused_tap;
    assign unused_tap = tap_in; // [R09]

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
            rst_prev_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= bus_reset_in;
            rst_sync_r <= rst_meta_r;
            rst_prev_r <= rst_sync_r;
        end
    end

    // ============================================================
    // decode
    bpr_state_t state_r, state_nxt;
    logic [`BPR_DET_W-1:0] cnt_r, cnt_nxt;
    logic ibr_r, ibr_nxt;
    logic ibr_write, own_detect, ext_detect, any_detect, regs_clr, mem_we;
    logic [`BPR_RDATA_W-1:0] mem_rdata;
    logic in_idle, in_drive;

    assign in_idle = state_r == BPR_IDLE;
    assign in_drive = state_r == BPR_DRIVE;
    assign ibr_write = reg_we && is_ctrl(reg_waddr) && reg_wdata[`BPR_IBR_BIT]; // [R07]
    // own reset counts as seen after the fixed count, not via pin loopback
    assign own_detect = in_drive && cnt_r == `BPR_DET_W'(`BPR_DET_CLKS - 1); // [R04] [R11]
    // prev idles low like the pin, so leaving reset gives no false edge
    assign ext_detect = rst_sync_r && !rst_prev_r;
    assign any_detect = own_detect || ext_detect; // [R06]
    // a request refused outside idle must not wipe the registers again
    assign regs_clr = (ibr_write && in_idle) || any_detect; // [R02]
    assign mem_we = reg_we && !regs_clr;

    // ============================================================
    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ibr_nxt = ibr_r;
        unique case (state_r)
            BPR_IDLE:
            begin
                cnt_nxt = '0;
                if (ibr_write)
                begin
                    ibr_nxt = 1'b1;
                    state_nxt = BPR_DRIVE; // [R01]
                end
                else if (ext_detect)
                    state_nxt = BPR_INIT; // [R06]
            end
            BPR_DRIVE:
            begin
                // the generator counter ignores detected resets so the pulse is full length
                cnt_nxt = cnt_r + `BPR_DET_W'(1); // [R05]
                if (own_detect)
                begin
                    ibr_nxt = 1'b0; // [R08]
                    state_nxt = BPR_INIT; // [R04]
                end
            end
            BPR_INIT:
            begin
                cnt_nxt = '0;
                state_nxt = BPR_IDLE; // [R03]
            end
            default:
                state_nxt = BPR_IDLE;
        endcase
    end

    // registered outputs follow the next state so they line up with state_r
    logic drive_nxt, init_nxt;
    assign drive_nxt = state_nxt == BPR_DRIVE;
    assign init_nxt = state_nxt == BPR_INIT;

    // ============================================================
    // state register; power-up lands in idle with no bus reset driven
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= BPR_IDLE; // [R10]
        else
            state_r <= state_nxt;
    end

    // detection counter; only the sequencer moves it, never a detected edge
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt; // [R05]
    end

    // request bit; once set only the own detect clears it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ibr_r <= 1'b0;
        else
            ibr_r <= ibr_nxt; // [R08]
    end

    // backplane drive and init pulse come straight from flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_reset_out <= 1'b0; // [R10]
            phy_init <= 1'b0;
        end
        else
        begin
            bus_reset_out <= drive_nxt; // [R01]
            phy_init <= init_nxt; // [R06]
        end
    end

    // ============================================================
    // outputs
    logic [`BPR_RDATA_W-1:0] rdata_r, rdata_nxt;
    // control word shows the live reset bit over the stored copy,
    // since the memory never holds that bit
    assign rdata_nxt = is_ctrl(reg_raddr) ? (mem_rdata | ibr_field(ibr_nxt)) : mem_rdata;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= `BPR_REG_RST;
        else
            rdata_r <= rdata_nxt;
    end

    // visible copy of the request bit, one flop so it matches bus_reset_out
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            initiate_bus_reset_bit <= 1'b0;
        else
            initiate_bus_reset_bit <= ibr_nxt; // [R08]
    end
    assign reg_rdata = rdata_r;

    bpr_regs u_regs
    (
        .clk(clk),
        .resetn(resetn),
        .clr(regs_clr), // [R02]
        .we(mem_we),
        .waddr(reg_waddr),
        .wdata(reg_wdata & ~ibr_field(1'b1)),
        .raddr(reg_raddr),
        .rdata(mem_rdata)
    );
endmodule

// ===== bench/bpr_chk.sv
// assertions for the bus reset sequencer
`timescale 1ns/1ps
module bpr_chk (
    // clock and reset
    input logic clk,
    input logic resetn,
    // link side
    input logic reg_we,
    input logic [1:0] reg_waddr,
    input logic [7:0] reg_wdata,
    input logic [1:0] reg_raddr,
    input logic [7:0] reg_rdata,
    // backplane and status
    input logic bus_reset_in,
    input logic tap_in,
    input logic bus_reset_out,
    input logic phy_init,
    input logic initiate_bus_reset_bit
);
    // ====
    // helpers: length of the current drive phase
    logic [9:0] cnt_r;
    wire wr = reg_we && reg_waddr == 2'h0 && reg_wdata[6];
    wire idle = !bus_reset_out && !phy_init;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) cnt_r <= 10'h000;
        else cnt_r <= bus_reset_out ? cnt_r + 10'h001 : 10'h000;
    // ====
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_REQ: assert property (wr && idle |=> bus_reset_out && initiate_bus_reset_bit)
        else $error("request not taken");
    AST_LEN: assert property ($rose(bus_reset_out) |-> ##[320:320] (phy_init && !bus_reset_out))
        else $error("own reset not detected on time");
    AST_HOLD: assert property ($fell(bus_reset_out) |-> cnt_r == 10'h140)
        else $error("drive phase cut or restarted");
    AST_BIT: assert property ($fell(initiate_bus_reset_bit) |-> phy_init && !bus_reset_out)
        else $error("reset bit cleared at wrong time");
    AST_CAUSE: assert property ($rose(bus_reset_out) |-> $past(wr) && $past(idle))
        else $error("bus reset without request");
    AST_CLR: assert property ($rose(bus_reset_out) ##0 (!reg_we && $stable(reg_raddr))[*4]
        |-> reg_rdata == (reg_raddr == 2'h0 ? 8'h40 : 8'h00))
        else $error("registers not back to defaults");
    AST_EXT: assert property ($rose(bus_reset_in) && idle |-> ##3 phy_init)
        else $error("external reset not followed by init");
    AST_TAP: assert property (tap_in && !wr && idle |=> !bus_reset_out)
        else $error("tap-in drove bus reset");
    cover property (wr && idle);
    cover property (wr && bus_reset_out);
    cover property ($rose(bus_reset_in) && idle);
endmodule

// ===== bench/bpr_node.sv
// other backplane node that can put its own bus reset on the line
`timescale 1ns/1ps
module bpr_node #(parameter int HOLD = 40) (
    // clock and trigger
    input logic clk,
    input logic start,
    // line level seen by the phy; idles low once the hold runs out
    output logic bus_level
);
    int n = 0;
    always @(posedge clk)
        if (start) n <= HOLD;
        else if (n > 0) n <= n - 1;
    assign bus_level = n > 0;
endmodule

// ===== bench/backplane_phy_bus_reset_tb_top.sv
// testbench for the bus reset sequencer
`timescale 1ns/1ps
module backplane_phy_bus_reset_tb_top;
    logic clk = 1'b0, resetn = 1'b0, reg_we = 1'b0, tap_in = 1'b0, start = 1'b0;
    logic [1:0] reg_waddr = 2'h0, reg_raddr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic bus_reset_in, bus_reset_out, phy_init, initiate_bus_reset_bit;
    int fails = 0, check_count = 0, n;
    always #5 clk = ~clk;
    bpr_node u_node (.clk(clk), .start(start), .bus_level(bus_reset_in));
    bpr_seq u_dut (.clk(clk), .resetn(resetn), .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
        .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .bus_reset_in(bus_reset_in), .tap_in(tap_in),
        .bus_reset_out(bus_reset_out), .phy_init(phy_init), .initiate_bus_reset_bit(initiate_bus_reset_bit));
    task tick(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(string name, logic [9:0] exp, logic [9:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(logic [1:0] a, logic [7:0] d);
        reg_we = 1'b1;
        reg_waddr = a;
        reg_wdata = d;
        tick();
        reg_we = 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // other node resets the bus while tap-in is active
    task t_ext;
        tap_in = 1'b1;
        start = 1'b1;
        tick();
        start = 1'b0;
        for (n = 0; phy_init !== 1'b1 && n < 10; n++) tick();
        chk("ext_latency", 10'h003, 10'(n));
        if (n >= 10) wrap_up();
        chk("ext_out", 10'h000, 10'(bus_reset_out));
        $display("test ext done");
    endtask
    // own reset with a refused request and a foreign edge mid-drive
    task t_req;
        reg_raddr = 2'h1;
        wr(2'h1, 8'h5A);
        tick();
        chk("out_early", 10'h000, 10'(bus_reset_out));
        wr(2'h0, 8'h40);
        chk("out", 10'h001, 10'(bus_reset_out));
        chk("bit", 10'h001, 10'(initiate_bus_reset_bit));
        tick(4);
        chk("cleared", 10'h000, 10'(reg_rdata));
        reg_raddr = 2'h0;
        start = 1'b1;
        wr(2'h0, 8'h40);
        start = 1'b0;
        chk("ctrl_live", 10'h040, 10'(reg_rdata));
        for (n = 5; bus_reset_out === 1'b1 && n < 400; n++) tick();
        chk("len", 10'h140, 10'(n));
        if (n >= 400) wrap_up();
        chk("init", 10'h001, 10'(phy_init));
        chk("bit_clr", 10'h000, 10'(initiate_bus_reset_bit));
        reg_raddr = 2'h0;
        tick(3);
        chk("ctrl", 10'h000, 10'(reg_rdata));
        $display("test req done");
    endtask
    initial
    begin
        tick(8);
        resetn = 1'b1;
        tick(20);
        chk("pwrup", 10'h000, 10'(bus_reset_out));
        t_ext();
        tick(50);
        t_req();
        wrap_up();
    end
endmodule
bind bpr_seq bpr_chk u_chk (.clk(clk), .resetn(resetn), .reg_we(reg_we), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .bus_reset_in(bus_reset_in),
    .tap_in(tap_in), .bus_reset_out(bus_reset_out), .phy_init(phy_init),
    .initiate_bus_reset_bit(initiate_bus_reset_bit));
